/* File: hdl/bjl_map.svh */
// Constants for the branch, jump and loop control block.
// Assumes inclusion by bare name from the files under hdl/.
`ifndef BJL_MAP_SVH
`define BJL_MAP_SVH
// Offset field widths, in bits, of each PC-relative transfer form
`define BJL_W_COND 21
`define BJL_W_FAR 25
`define BJL_W_BLSHORT 13
`define BJL_W_CMP 9
`define BJL_W_ZERO 8
`define BJL_W_LOOP_S 13
`define BJL_W_LOOP_U 7
// Width of the compare immediate
`define BJL_W_IMM 6
// Alignment masks for halfword and word targets
`define BJL_HALF_MASK 32'hFFFF_FFFE
`define BJL_WORD_MASK 32'hFFFF_FFFC
// Reset values
`define BJL_ADDR_RST 32'h0000_0000
`define BJL_COUNT_RST 32'h0000_0000
// Transfer takes effect this many cycles after issue
`define BJL_XFER_LAT 1
`endif

/* File: hdl/bjl_pkg.sv */
// Types shared by the branch, jump and loop control block.
// Assumes nothing beyond a SystemVerilog compiler.
package bjl_pkg;
    // Decoded flow instruction class
    typedef enum logic [3:0] {
        BJL_OP_NONE, BJL_OP_BCC, BJL_OP_BFAR, BJL_OP_COND_BRANCH_LINK, BJL_OP_BLFAR,
        BJL_OP_BLSHORT, BJL_OP_CMPBR, BJL_OP_BITCLR, BJL_OP_BITSET,
        BJL_OP_ZERO, BJL_OP_NZERO, BJL_OP_JUMP, BJL_OP_JLINK, BJL_OP_LOOP
    } bjl_op_t;
    // Compare conditions of the compare-and-branch forms
    typedef enum logic [2:0] {
        BJL_CC_EQ, BJL_CC_NE, BJL_CC_LT, BJL_CC_GE, BJL_CC_LO, BJL_CC_HS
    } bjl_cmp_t;
    // Operand format of the loop setup instruction
    typedef enum logic [2:0] {
        BJL_FMT_RR, BJL_FMT_U6, BJL_FMT_S12, BJL_FMT_CR, BJL_FMT_CU6
    } bjl_fmt_t;
    // Jump source register class
    typedef enum logic [1:0] {
        BJL_SRC_REG, BJL_SRC_IRQ1, BJL_SRC_IRQ2
    } bjl_src_t;
    // Loop control register selection for auxiliary access
    typedef enum logic {
        BJL_AUX_BEGIN, BJL_AUX_FINAL
    } bjl_aux_t;
endpackage

/* File: hdl/bjl_cmp.sv */
// Condition evaluator for compare-and-branch and bit-test branches.
// Assumes operands are already read from the register file.
`timescale 1ns/1ps
`default_nettype none
module bjl_cmp (
    input wire logic [31:0] b_in,
    input wire logic [31:0] c_in,
    input wire bjl_pkg::bjl_cmp_t cond_in,
    input wire logic bit_test_in,
    input wire logic bit_set_in,
    output logic taken_out
);
    import bjl_pkg::*;
    logic [32:0] diff;
    logic zero;
    logic neg_ovf;
    // Subtraction compare b - c; result only feeds the decision
    always_comb begin
        diff = {1'b0, b_in} - {1'b0, c_in};
        zero = (diff[31:0] == 32'h0000_0000);
        neg_ovf = diff[31] ^ ((b_in[31] ^ c_in[31]) & (b_in[31] ^ diff[31]));
    end
    // Pick the tested relation
    always_comb begin
        if (bit_test_in) begin
            taken_out = (b_in[c_in[4:0]] == bit_set_in);
        end else begin
            unique case (cond_in)
                BJL_CC_EQ: taken_out = zero;
                BJL_CC_NE: taken_out = !zero;
                BJL_CC_LT: taken_out = neg_ovf;
                BJL_CC_GE: taken_out = !neg_ovf;
                BJL_CC_LO: taken_out = diff[32];
                BJL_CC_HS: taken_out = !diff[32];
                default: taken_out = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: hdl/bjl_loop.sv */
// Zero overhead loop registers and loop-end redirect.
// Assumes fetch presents each sequential fetch address with a valid strobe.
`include "bjl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bjl_loop (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic setup_in,
    input wire logic [31:0] setup_begin_in,
    input wire logic [31:0] setup_final_in,
    input wire logic aux_we_in,
    input wire bjl_pkg::bjl_aux_t aux_sel_in,
    input wire logic [31:0] aux_wdata_in,
    input wire logic count_we_in,
    input wire logic [31:0] count_wdata_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_pc_in,
    output logic loop_jump_out,
    output logic [31:0] loop_begin_out,
    output logic [31:0] loop_final_out,
    output logic [31:0] loop_count_out
);
    import bjl_pkg::*;
    logic end_hit;
    // End compare runs beside fetch, so no cycle is lost to it
    assign end_hit = fetch_valid_in && (fetch_pc_in == loop_final_out);
    assign loop_jump_out = end_hit && (loop_count_out != 32'h0000_0001);
    // Loop start and end; setup wins over an auxiliary write
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_begin_out <= `BJL_ADDR_RST;
            loop_final_out <= `BJL_ADDR_RST;
        end else if (setup_in) begin
            loop_begin_out <= setup_begin_in;
            loop_final_out <= setup_final_in;
        end else if (aux_we_in) begin
            if (aux_sel_in == BJL_AUX_BEGIN) begin
                loop_begin_out <= aux_wdata_in;
            end else begin
                loop_final_out <= aux_wdata_in;
            end
        end
    end
    // Iteration count; a core write wins over the end decrement
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            loop_count_out <= `BJL_COUNT_RST;
        end else if (count_we_in) begin
            loop_count_out <= count_wdata_in;
        end else if (end_hit) begin
            loop_count_out <= loop_count_out - 32'h0000_0001;
        end
    end
    AST_LOOP_DEC: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        end_hit && !count_we_in |=>
        loop_count_out == $past(loop_count_out) - 32'h0000_0001)
        else $error("loop count not decremented at loop end");
endmodule
`default_nettype wire

/* File: hdl/bjl_ctrl.sv */
// Program flow control: branches, jumps, loop setup and loop end.
// Assumes decode supplies a classified instruction with its operands,
// flag condition result and delay mode, all on ref_clk_in.
`include "bjl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bjl_ctrl #(
    parameter int EXTRA_SLOTS = 0
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic issue_valid_in,
    input wire bjl_pkg::bjl_op_t op_kind_in,
    input wire logic delay_always_in,
    input wire logic cond_true_in,
    input wire bjl_pkg::bjl_cmp_t cmp_cond_in,
    input wire logic cmp_imm_in,
    input wire logic [5:0] imm6_in,
    input wire bjl_pkg::bjl_fmt_t loop_fmt_in,
    input wire bjl_pkg::bjl_src_t jump_src_in,
    input wire logic flag_set_in,
    input wire logic [31:0] pc_in,
    input wire logic [31:0] next_pc_in,
    input wire logic [31:0] offset_in,
    input wire logic [31:0] operand_b_in,
    input wire logic [31:0] operand_c_in,
    input wire logic [31:0] status_save_level1_in,
    input wire logic [31:0] status_save_level2_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_pc_in,
    input wire logic aux_write_op_in,
    input wire bjl_pkg::bjl_aux_t aux_sel_in,
    input wire logic [31:0] aux_wdata_in,
    input wire logic count_we_in,
    input wire logic [31:0] count_wdata_in,
    output logic redirect_out,
    output logic [31:0] redirect_pc_out,
    output logic [2:0] slot_kill_out,
    output logic link_we_out,
    output logic [31:0] link_data_out,
    output logic status_we_out,
    output logic [31:0] status_word_out,
    output logic insn_error_out,
    output logic [31:0] loop_begin_addr_out,
    output logic [31:0] loop_final_addr_out,
    output logic [31:0] loop_iter_count_out
);
    import bjl_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************

    // Sign extend the low w bits of a raw offset field
    function automatic logic [31:0] bjl_sext(input logic [31:0] raw,
                                             input int w);
        logic [31:0] r;
        r = raw;
        for (int i = 0; i < 32; i++) begin
            r[i] = (i < w) ? raw[i] : raw[w-1];
        end
        return r;
    endfunction

    // Zero extend the low w bits of a raw offset field
    function automatic logic [31:0] bjl_zext(input logic [31:0] raw,
                                             input int w);
        logic [31:0] r;
        r = raw;
        for (int i = 0; i < 32; i++) begin
            r[i] = (i < w) ? raw[i] : 1'b0;
        end
        return r;
    endfunction

    // ****************************************
    // Decision
    // ****************************************

    logic [31:0] cmp_c;
    logic cmp_taken;
    logic is_bit;
    logic is_cmp;
    logic is_link_br;
    logic loop_bad;
    logic loop_jump;
    logic next_setup;
    logic next_taken;
    logic [31:0] next_target;

    // Immediate compare operand is an unsigned 6-bit value
    assign cmp_c = cmp_imm_in ? {26'h000_0000, imm6_in} : operand_c_in;
    assign is_bit = (op_kind_in == BJL_OP_BITCLR) ||
                    (op_kind_in == BJL_OP_BITSET);
    assign is_cmp = (op_kind_in == BJL_OP_CMPBR) || is_bit;
    assign is_link_br = (op_kind_in == BJL_OP_COND_BRANCH_LINK) ||
                        (op_kind_in == BJL_OP_BLFAR) ||
                        (op_kind_in == BJL_OP_BLSHORT);
    // Register formats of loop setup are not implemented
    assign loop_bad = (op_kind_in == BJL_OP_LOOP) &&
                      ((loop_fmt_in == BJL_FMT_RR) ||
                       (loop_fmt_in == BJL_FMT_CR));

    bjl_cmp u_cmp (
        .b_in(operand_b_in),
        .c_in(cmp_c),
        .cond_in(cmp_cond_in),
        .bit_test_in(is_bit),
        .bit_set_in(op_kind_in == BJL_OP_BITSET),
        .taken_out(cmp_taken)
    );

    // Taken decision and target address per instruction class
    always_comb begin
        next_taken = 1'b0;
        next_setup = 1'b0;
        next_target = pc_in;
        unique case (op_kind_in)
            BJL_OP_BCC: begin
                next_taken = cond_true_in;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_COND);
            end
            BJL_OP_BFAR: begin
                next_taken = 1'b1;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_FAR);
            end
            BJL_OP_COND_BRANCH_LINK: begin
                next_taken = cond_true_in;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_COND);
            end
            BJL_OP_BLFAR: begin
                next_taken = 1'b1;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_FAR);
            end
            BJL_OP_BLSHORT: begin
                next_taken = 1'b1;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_BLSHORT);
            end
            BJL_OP_CMPBR, BJL_OP_BITCLR, BJL_OP_BITSET: begin
                next_taken = cmp_taken;
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_CMP);
            end
            BJL_OP_ZERO: begin
                next_taken = (operand_b_in == 32'h0000_0000);
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_ZERO);
            end
            BJL_OP_NZERO: begin
                next_taken = (operand_b_in != 32'h0000_0000);
                next_target = pc_in + bjl_sext(offset_in, `BJL_W_ZERO);
            end
            BJL_OP_JUMP, BJL_OP_JLINK: begin
                next_taken = cond_true_in;
                next_target = operand_c_in;
            end
            BJL_OP_LOOP: begin
                if (loop_fmt_in == BJL_FMT_S12) begin
                    next_target = pc_in + bjl_sext(offset_in, `BJL_W_LOOP_S);
                end else begin
                    next_target = pc_in + bjl_zext(offset_in, `BJL_W_LOOP_U);
                end
                next_taken = !loop_bad && !cond_true_in;
                next_setup = !loop_bad && cond_true_in;
            end
            default: begin
                next_taken = 1'b0;
            end
        endcase
        // Branch-and-link forms need word targets, the rest halfword targets
        if (is_link_br) begin
            next_target = next_target & `BJL_WORD_MASK;
        end else begin
            next_target = next_target & `BJL_HALF_MASK;
        end
    end

    // ****************************************
    // Loop registers
    // ****************************************

    bjl_loop u_loop (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .setup_in(issue_valid_in && next_setup),
        .setup_begin_in(next_pc_in),
        .setup_final_in(next_target),
        .aux_we_in(aux_write_op_in),
        .aux_sel_in(aux_sel_in),
        .aux_wdata_in(aux_wdata_in),
        .count_we_in(count_we_in),
        .count_wdata_in(count_wdata_in),
        .fetch_valid_in(fetch_valid_in),
        .fetch_pc_in(fetch_pc_in),
        .loop_jump_out(loop_jump),
        .loop_begin_out(loop_begin_addr_out),
        .loop_final_out(loop_final_addr_out),
        .loop_count_out(loop_iter_count_out)
    );

    // ****************************************
    // Registered outputs
    // ****************************************

    // Redirect one cycle after issue; the older branch beats loop end
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            redirect_out <= 1'b0;
            redirect_pc_out <= `BJL_ADDR_RST;
        end else if (issue_valid_in && next_taken) begin
            redirect_out <= 1'b1;
            redirect_pc_out <= next_target;
        end else begin
            redirect_out <= loop_jump;
            redirect_pc_out <= loop_begin_addr_out;
        end
    end

    // Slots to squash: first per mode, extra compare slots always
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            slot_kill_out <= 3'h0;
        end else begin
            slot_kill_out <= 3'h0;
            if (issue_valid_in && next_taken) begin
                slot_kill_out[0] <= !delay_always_in;
                for (int i = 1; i < 3; i++) begin
                    slot_kill_out[i] <= is_cmp && (i <= EXTRA_SLOTS);
                end
            end
        end
    end

    // Link write of the sequential address for linking forms
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_we_out <= 1'b0;
            link_data_out <= `BJL_ADDR_RST;
        end else begin
            link_we_out <= issue_valid_in && next_taken &&
                           (is_link_br || op_kind_in == BJL_OP_JLINK);
            link_data_out <= next_pc_in;
        end
    end

    // Status restore on flag-setting return through an interrupt link
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_we_out <= 1'b0;
            status_word_out <= `BJL_ADDR_RST;
        end else begin
            status_we_out <= issue_valid_in && next_taken && flag_set_in &&
                             (op_kind_in == BJL_OP_JUMP) &&
                             (jump_src_in != BJL_SRC_REG);
            status_word_out <= (jump_src_in == BJL_SRC_IRQ2) ?
                               status_save_level2_in : status_save_level1_in;
        end
    end

    // Illegal loop setup format raises an instruction error pulse
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            insn_error_out <= 1'b0;
        end else begin
            insn_error_out <= issue_valid_in && loop_bad;
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    AST_ALWAYS_SLOT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && next_taken && delay_always_in |=> !slot_kill_out[0])
        else $error("delay slot killed in always-execute mode");
    AST_JUMP_LAT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && op_kind_in == BJL_OP_JUMP && cond_true_in |=>
        redirect_out && redirect_pc_out == ($past(operand_c_in) & `BJL_HALF_MASK))
        else $error("jump not redirected one cycle after issue");
    AST_CMP_NOWRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && is_cmp |=> !status_we_out && !link_we_out)
        else $error("compare branch wrote flags or link");
    AST_EXTRA_KILL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && is_cmp && cmp_taken && EXTRA_SLOTS > 0 |=>
        slot_kill_out[1])
        else $error("extra compare slot not killed");
    AST_IRQ_RESTORE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && op_kind_in == BJL_OP_JUMP && cond_true_in &&
        flag_set_in && jump_src_in == BJL_SRC_IRQ1 |=>
        status_we_out && status_word_out == $past(status_save_level1_in))
        else $error("level 1 status not restored");
    AST_JLINK: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && op_kind_in == BJL_OP_JLINK && cond_true_in |=>
        link_we_out && link_data_out == $past(next_pc_in))
        else $error("jump-and-link did not write link");
    AST_LINK_ALIGN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && is_link_br && next_taken |=>
        redirect_pc_out[1:0] == 2'h0)
        else $error("link branch target not word aligned");
    AST_LOOP_ERR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && loop_bad |=> insn_error_out ##1
        (!insn_error_out || $past(issue_valid_in && loop_bad)))
        else $error("bad loop format without single error pulse");
    AST_LOOP_SETUP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        issue_valid_in && next_setup && !aux_write_op_in |=>
        loop_begin_addr_out == $past(next_pc_in))
        else $error("loop start not loaded by setup");
endmodule
`default_nettype wire

/* File: verification/bjl_fetch_model.sv */
// Fetch stage model that sits in front of the flow control block.
// Assumes the bench holds en_in low while start_pc_in is loaded.
`timescale 1ns/1ps
`default_nettype none
module bjl_fetch_model (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic [31:0] start_pc_in,
    input wire logic redirect_in,
    input wire logic [31:0] redirect_pc_in,
    output logic valid_out,
    output logic [31:0] pc_out
);
    logic [31:0] pc;
    // Fetch moves on the falling edge, off the block's sampling edge
    initial begin
        valid_out = 1'b0;
        pc_out = 32'h0000_0000;
        pc = 32'h0000_0000;
        forever begin
            @(negedge clk_in);
            if (!en_in) begin
                pc = start_pc_in;
                valid_out = 1'b0;
                // Idle bus flips, so no stale address can match
                pc_out = ~pc_out;
            end else begin
                // Targets are whole instructions, never a delay slot
                pc = redirect_in ? redirect_pc_in : pc + 32'h0000_0004;
                valid_out = 1'b1;
                pc_out = pc;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/branch_jump_loop_control_bench.sv */
// Self-checking bench for the branch, jump and loop control block.
// Assumes bjl_pkg is compiled first and the fetch model beside it.
`timescale 1ns/1ps
`default_nettype none
module branch_jump_loop_control_bench;
    import bjl_pkg::*;
    typedef struct {
        bjl_op_t op;
        bjl_cmp_t cc;
        logic t, d;
        logic [31:0] b, c, off;
        logic r;
        logic [31:0] pc;
    } bjl_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic iv = 1'b0;
    bjl_row_t cur;
    bjl_fmt_t fmt = BJL_FMT_S12;
    bjl_src_t src = BJL_SRC_REG;
    bjl_aux_t asel = BJL_AUX_BEGIN;
    logic cimm = 1'b0, fs = 1'b0, awe = 1'b0, cwe = 1'b0, fen = 1'b0;
    logic [5:0] imm = 6'h00;
    logic [31:0] awd = 32'h0000_0000, cwd = 32'h0000_0000;
    logic fv, rd, lwe, swe, ierr;
    logic [31:0] fpc, rpc, ldat, sw, lbeg, lfin, lcnt;
    logic [2:0] kill;
    int fails = 0, comparisons = 0, nred;
    bjl_row_t rw [16];
    // One-slot option so the extra compare slot is visible
    bjl_ctrl #(.EXTRA_SLOTS(1)) bjl_ctrl_inst (
        .ref_clk_in(clk), .rst_in(rst), .issue_valid_in(iv),
        .op_kind_in(cur.op), .delay_always_in(cur.d),
        .cond_true_in(cur.t), .cmp_cond_in(cur.cc), .cmp_imm_in(cimm),
        .imm6_in(imm), .loop_fmt_in(fmt), .jump_src_in(src),
        .flag_set_in(fs), .pc_in(32'h0000_1000), .next_pc_in(32'h0000_1004),
        .offset_in(cur.off), .operand_b_in(cur.b), .operand_c_in(cur.c),
        .status_save_level1_in(32'h1111_1111),
        .status_save_level2_in(32'h2222_2222),
        .fetch_valid_in(fv), .fetch_pc_in(fpc), .aux_write_op_in(awe),
        .aux_sel_in(asel), .aux_wdata_in(awd), .count_we_in(cwe),
        .count_wdata_in(cwd), .redirect_out(rd), .redirect_pc_out(rpc),
        .slot_kill_out(kill), .link_we_out(lwe), .link_data_out(ldat),
        .status_we_out(swe), .status_word_out(sw), .insn_error_out(ierr),
        .loop_begin_addr_out(lbeg), .loop_final_addr_out(lfin),
        .loop_iter_count_out(lcnt));
    bjl_fetch_model bjl_fetch_model_inst (
        .clk_in(clk), .en_in(fen), .start_pc_in(32'h0000_1034),
        .redirect_in(rd), .redirect_pc_in(rpc), .valid_out(fv),
        .pc_out(fpc));
    always #50 clk = ~clk;
    // Case-equality compare so an unknown never passes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One issue cycle; outputs stand in the following cycle
    task automatic issue(input bjl_row_t r);
        @(negedge clk);
        cur = r;
        iv = 1'b1;
        @(negedge clk);
        iv = 1'b0;
    endtask
    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, far beyond the roughly 115 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        summarize();
    end
    // Table of plain transfers from an instruction at 0x1000
    initial begin
        rw[0] = '{BJL_OP_BCC, BJL_CC_EQ, 1, 0, 0, 0, 32'h0000_0101, 1, 32'h0000_1100};
        rw[1] = '{BJL_OP_BCC, BJL_CC_EQ, 1, 1, 0, 0, 32'h001F_FFFE, 1, 32'h0000_0FFE};
        rw[2] = '{BJL_OP_BFAR, BJL_CC_EQ, 1, 0, 0, 0, 32'h01FF_FFF0, 1, 32'h0000_0FF0};
        rw[3] = '{BJL_OP_COND_BRANCH_LINK, BJL_CC_EQ, 1, 0, 0, 0, 32'h0000_0102, 1, 32'h0000_1100};
        rw[4] = '{BJL_OP_BLSHORT, BJL_CC_EQ, 1, 0, 0, 0, 32'h0000_1FFC, 1, 32'h0000_0FFC};
        rw[5] = '{BJL_OP_CMPBR, BJL_CC_EQ, 0, 0, 5, 5, 32'h0000_01FE, 1, 32'h0000_0FFE};
        rw[6] = '{BJL_OP_CMPBR, BJL_CC_NE, 0, 0, 5, 5, 32'h0000_0010, 0, 0};
        rw[7] = '{BJL_OP_CMPBR, BJL_CC_LT, 0, 1, 32'hFFFF_FFFF, 1, 32'h0000_0010, 1, 32'h0000_1010};
        rw[8] = '{BJL_OP_CMPBR, BJL_CC_LO, 0, 0, 32'hFFFF_FFFF, 1, 32'h0000_0010, 0, 0};
        rw[9] = '{BJL_OP_CMPBR, BJL_CC_GE, 0, 0, 1, 32'hFFFF_FFFF, 32'h0000_0010, 1, 32'h0000_1010};
        rw[10] = '{BJL_OP_CMPBR, BJL_CC_HS, 0, 0, 32'hFFFF_FFFF, 1, 32'h0000_0010, 1, 32'h0000_1010};
        rw[11] = '{BJL_OP_BITCLR, BJL_CC_EQ, 0, 0, 32'hFFFF_FFFE, 0, 32'h0000_0010, 1, 32'h0000_1010};
        rw[12] = '{BJL_OP_BITSET, BJL_CC_EQ, 0, 0, 32'h8000_0000, 31, 32'h0000_0010, 1, 32'h0000_1010};
        rw[13] = '{BJL_OP_ZERO, BJL_CC_EQ, 0, 0, 0, 0, 32'h0000_00FE, 1, 32'h0000_0FFE};
        rw[14] = '{BJL_OP_NZERO, BJL_CC_EQ, 0, 0, 0, 0, 32'h0000_00FE, 0, 0};
        rw[15] = '{BJL_OP_JUMP, BJL_CC_EQ, 1, 1, 0, 32'h0000_0101, 0, 1, 32'h0000_0100};
        cur = rw[0];
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (rw[i]) begin
            issue(rw[i]);
            chk(rd, rw[i].r);
            if (rw[i].r) chk(rpc, rw[i].pc);
            if (rw[i].r) chk(kill[0], !rw[i].d);
            if (rw[i].r && rw[i].op == BJL_OP_CMPBR)
                chk(kill[2:1], 2'b01);
            chk(swe, 1'b0);
        end
        $display("table done");
        issue('{BJL_OP_JLINK, BJL_CC_EQ, 1, 0, 0, 32'h0000_2003, 0, 1, 0});
        chk(lwe, 1'b1);
        chk(ldat, 32'h0000_1004);
        chk(rpc, 32'h0000_2002);
        for (int s = 1; s < 3; s++) begin
            src = bjl_src_t'(s);
            fs = 1'b1;
            issue('{BJL_OP_JUMP, BJL_CC_EQ, 1, 0, 0, 32'h0000_3000, 0, 1, 0});
            chk(swe, 1'b1);
            chk(sw, s == 1 ? 32'h1111_1111 : 32'h2222_2222);
        end
        fs = 1'b0;
        cimm = 1'b1;
        imm = 6'h3F;
        // Top of the immediate range must still compare in full
        issue('{BJL_OP_CMPBR, BJL_CC_EQ, 0, 0, 63, 0, 32'h0000_0010, 1, 0});
        chk(rd, 1'b1);
        cimm = 1'b0;
        // Greater-than comes from less-than with the operands swapped
        issue('{BJL_OP_CMPBR, BJL_CC_LT, 0, 0, 1, 5, 32'h0000_0010, 1, 0});
        chk(rd, 1'b1);
        issue('{BJL_OP_CMPBR, BJL_CC_LT, 0, 0, 5, 5, 32'h0000_0010, 0, 0});
        chk(rd, 1'b0);
        $display("jump and immediate done");
        for (int f = 0; f < 4; f += 3) begin
            fmt = bjl_fmt_t'(f);
            issue('{BJL_OP_LOOP, BJL_CC_EQ, 1, 0, 0, 0, 32'h0000_0040, 0, 0});
            chk(ierr, 1'b1);
            chk(rd, 1'b0);
        end
        fmt = BJL_FMT_CU6;
        issue('{BJL_OP_LOOP, BJL_CC_EQ, 0, 0, 0, 0, 32'h0000_0070, 0, 0});
        chk(rpc, 32'h0000_1070);
        fmt = BJL_FMT_S12;
        issue('{BJL_OP_LOOP, BJL_CC_EQ, 0, 0, 0, 0, 32'h0000_1FF0, 0, 0});
        chk(rpc, 32'h0000_0FF0);
        issue('{BJL_OP_LOOP, BJL_CC_EQ, 1, 0, 0, 0, 32'h0000_0040, 0, 0});
        chk(rd, 1'b0);
        chk(lbeg, 32'h0000_1004);
        chk(lfin, 32'h0000_1040);
        // Aux write moves the loop start; count written as core register
        awe = 1'b1;
        awd = 32'h0000_1008;
        cwe = 1'b1;
        cwd = 32'h0000_0002;
        @(negedge clk);
        awe = 1'b0;
        cwe = 1'b0;
        @(negedge clk);
        chk(lbeg, 32'h0000_1008);
        chk(lcnt, 32'h0000_0002);
        fen = 1'b1;
        nred = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (rd) begin
                nred++;
                chk(fpc, 32'h0000_1040);
                chk(rpc, 32'h0000_1008);
            end
        end
        chk(nred, 1);
        chk(lcnt, 0);
        @(negedge clk);
        fen = 1'b0;
        $display("loop done");
        // Aux write to the loop end register
        asel = BJL_AUX_FINAL;
        awe = 1'b1;
        awd = 32'h0000_1010;
        @(negedge clk);
        awe = 1'b0;
        @(negedge clk);
        chk(lfin, 32'h0000_1010);
        // Reset in mid-run clears the loop state
        rst = 1'b1;
        @(negedge clk);
        chk(lfin, 0);
        chk(lbeg, 0);
        chk(rd, 1'b0);
        rst = 1'b0;
        issue(rw[0]);
        chk(rpc, 32'h0000_1100);
        $display("reset done");
        summarize();
    end
endmodule
`default_nettype wire
